// >>> include/ipw_defs.vh
// ipw_defs.vh: offsets, field positions, reset values and timing for the
// indexed-port watchdog. definitions only; included by bare name.
`ifndef IPW_DEFS_VH
`define IPW_DEFS_VH

`define IPW_PORT_INDEX     1'b0
`define IPW_PORT_DATA      1'b1
`define IPW_KEY_UNLOCK     8'h87
`define IPW_KEY_LOCK       8'haa
`define IPW_IDX_DEVSEL     8'h07
`define IPW_IDX_ACTIVATE   8'h30
`define IPW_IDX_UNIT       8'hf5
`define IPW_IDX_COUNT      8'hf6
`define IPW_IDX_CTRL       8'hf7
`define IPW_DEV_WATCHDOG   8'h08
`define IPW_ACT_BIT        0
`define IPW_UNIT_BIT       3
`define IPW_CTRL_MOUSE     7
`define IPW_CTRL_KBD       6
`define IPW_CTRL_FORCE     5
`define IPW_CTRL_STATUS    4
`define IPW_UNIT_RST       8'h00
`define IPW_COUNT_RST      8'h00
`define IPW_CTRL_RST       8'h00
`define IPW_ACT_RST        8'h00
`define IPW_CLK_HZ         100000000
`define IPW_SEC_PER_MIN    60

`endif

// >>> rtl/ipw_sync3.v
// ipw_sync3.v: three-flop synchroniser for a pin level.
// assumes an asynchronous level input; output changes only when stages 2 and 3 agree.
`timescale 1ns/1ps
module ipw_sync3 (
  input  wire clock,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clock) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // ipw_sync3

// >>> rtl/ipw_tick.v
// ipw_tick.v: prescaler giving one-cycle second and minute enables.
// assumes clock at CLK_HZ; counts restart on clear so a restart gets full periods.
`timescale 1ns/1ps
`include "ipw_defs.vh"
module ipw_tick #(
  parameter CLK_HZ  = `IPW_CLK_HZ,
  parameter PER_MIN = `IPW_SEC_PER_MIN
) (
  input  wire clock,
  input  wire reset,
  input  wire clear,
  output reg  sec_tick,
  output reg  min_tick
);
  reg [31:0] cyc_q;
  reg [7:0]  sec_q;

  always @(posedge clock) begin
    if (reset || clear) begin
      cyc_q    <= 32'h0;
      sec_q    <= 8'h0;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      if (cyc_q == CLK_HZ - 1) begin
        cyc_q    <= 32'h0;
        sec_tick <= 1'b1;
        if (sec_q == PER_MIN - 1) begin
          sec_q    <= 8'h0;
          min_tick <= 1'b1;
        end else begin
          sec_q <= sec_q + 8'h1;
        end
      end else begin
        cyc_q <= cyc_q + 32'h1;
      end
    end
  end
endmodule // ipw_tick

// >>> rtl/ipw_watchdog.v
// ipw_watchdog.v: watchdog behind an index/data port pair with unlock keys.
// assumes a single-cycle host strobe per port access on the same clock;
// keyboard, mouse and strap arrive from pins and are synchronised here.
// How it works
// - host writes an index to the address port, then accesses data port
// - two consecutive unlock-key writes to the address port enter config mode
// - lock key leaves config mode; index and data writes then do nothing
// - writing the watchdog code to device-select routes later accesses here
// - writing one to activation enables the watchdog; disabled after reset
// - unit bit 3 picks seconds (zero, reset) or minutes (one)
// - 8-bit count; zero stops the timer and is the reset value
// - any count write restarts the countdown from the written value
// - count running out asserts the timeout output
// - control bit 6 lets keyboard activity restart the timer
// - control bit 5 forces timeout at once while activated and clears itself
// - control bit 4 reads one once timeout has occurred
// - interrupt output is active low and held until restart
// - strap picks reset or interrupt line 11 as the timeout target
// - control bit 7 lets mouse activity restart the timer
`timescale 1ns/1ps
`include "ipw_defs.vh"
module ipw_watchdog #(
  parameter CLK_HZ  = `IPW_CLK_HZ,
  parameter PER_MIN = `IPW_SEC_PER_MIN
) (
  input  wire       clock,
  input  wire       reset,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire       io_port,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       kbd_activity,
  input  wire       mouse_activity,
  input  wire       timeout_action_strap,
  output reg        irq11_n,
  output reg        sys_reset
);
  reg       unlock_half_q;
  reg       cfg_mode_q;
  reg [7:0] index_q;
  reg [7:0] devsel_q;
  reg       active_q;
  reg [7:0] unit_q;
  reg [7:0] count_q;
  reg [7:0] remain_q;
  reg       mouse_en_q;
  reg       kbd_en_q;
  reg       timeout_q;
  reg       kbd_prev_q;
  reg       mouse_prev_q;

  wire kbd_s;
  wire mouse_s;
  wire strap_s;
  wire sec_tick;
  wire min_tick;

  ipw_sync3 u_kbd (
    .clock (clock),
    .reset (reset),
    .din   (kbd_activity),
    .dout  (kbd_s)
  );
  ipw_sync3 u_mouse (
    .clock (clock),
    .reset (reset),
    .din   (mouse_activity),
    .dout  (mouse_s)
  );
  ipw_sync3 u_strap (
    .clock (clock),
    .reset (reset),
    .din   (timeout_action_strap),
    .dout  (strap_s)
  );

  wire idx_wr  = io_wr && (io_port == `IPW_PORT_INDEX);
  wire dat_wr  = io_wr && (io_port == `IPW_PORT_DATA) && cfg_mode_q;
  wire wd_sel  = (devsel_q == `IPW_DEV_WATCHDOG);
  wire wd_wr   = dat_wr && wd_sel;
  wire cnt_wr  = wd_wr && (index_q == `IPW_IDX_COUNT);
  wire ctl_wr  = wd_wr && (index_q == `IPW_IDX_CTRL);
  wire force_w = ctl_wr && io_wdata[`IPW_CTRL_FORCE];
  wire kbd_hit = kbd_en_q && kbd_s && !kbd_prev_q;
  wire ms_hit  = mouse_en_q && mouse_s && !mouse_prev_q;
  wire restart = cnt_wr || ((kbd_hit || ms_hit) && count_q != 8'h00);
  wire unit_tk = unit_q[`IPW_UNIT_BIT] ? min_tick : sec_tick;
  wire expire  = active_q && !timeout_q && remain_q == 8'h01 && unit_tk;

  // prescaler restarts with the count so the first period is whole
  ipw_tick #(
    .CLK_HZ  (CLK_HZ),
    .PER_MIN (PER_MIN)
  ) u_tick (
    .clock    (clock),
    .reset    (reset),
    .clear    (restart),
    .sec_tick (sec_tick),
    .min_tick (min_tick)
  );

  // key sequence and index latch
  always @(posedge clock) begin
    if (reset) begin
      unlock_half_q <= 1'b0;
      cfg_mode_q    <= 1'b0;
      index_q       <= 8'h00;
    end else if (idx_wr) begin
      if (!cfg_mode_q) begin
        if (io_wdata == `IPW_KEY_UNLOCK) begin
          unlock_half_q <= 1'b1;
          if (unlock_half_q) begin
            cfg_mode_q <= 1'b1;
          end
        end else begin
          unlock_half_q <= 1'b0;
        end
      end else if (io_wdata == `IPW_KEY_LOCK) begin
        cfg_mode_q    <= 1'b0;
        unlock_half_q <= 1'b0;
      end else begin
        index_q <= io_wdata;
      end
    end
  end

  // configuration registers
  always @(posedge clock) begin
    if (reset) begin
      devsel_q   <= 8'h00;
      active_q   <= 1'b0;
      unit_q     <= `IPW_UNIT_RST;
      count_q    <= `IPW_COUNT_RST;
      mouse_en_q <= 1'b0;
      kbd_en_q   <= 1'b0;
    end else begin
      if (dat_wr && index_q == `IPW_IDX_DEVSEL) begin
        devsel_q <= io_wdata;
      end
      if (wd_wr && index_q == `IPW_IDX_ACTIVATE) begin
        active_q <= io_wdata[`IPW_ACT_BIT];
      end
      if (wd_wr && index_q == `IPW_IDX_UNIT) begin
        unit_q <= io_wdata;
      end
      if (cnt_wr) begin
        count_q <= io_wdata;
      end
      if (ctl_wr) begin
        mouse_en_q <= io_wdata[`IPW_CTRL_MOUSE];
        kbd_en_q   <= io_wdata[`IPW_CTRL_KBD];
      end
    end
  end

  // countdown and timeout flag
  always @(posedge clock) begin
    if (reset) begin
      remain_q     <= `IPW_COUNT_RST;
      timeout_q    <= 1'b0;
      kbd_prev_q   <= 1'b0;
      mouse_prev_q <= 1'b0;
    end else begin
      kbd_prev_q   <= kbd_s;
      mouse_prev_q <= mouse_s;
      if (force_w && active_q) begin
        timeout_q <= 1'b1;
      end else if (expire) begin
        // expiry wins over a strobe in the same cycle; the strobe still reloads
        remain_q  <= restart ? (cnt_wr ? io_wdata : count_q) : 8'h00;
        timeout_q <= 1'b1;
      end else if (restart) begin
        // count write restarts from new value; activity reloads the held one
        remain_q  <= cnt_wr ? io_wdata : count_q;
        timeout_q <= 1'b0;
      end else if (active_q && remain_q > 8'h01 && unit_tk) begin
        remain_q <= remain_q - 8'h01;
      end
    end
  end

  // timeout target and data readback
  always @(posedge clock) begin
    if (reset) begin
      irq11_n   <= 1'b1;
      sys_reset <= 1'b0;
      io_rdata  <= 8'h00;
    end else begin
      irq11_n   <= !(timeout_q && !strap_s);
      sys_reset <= timeout_q && strap_s;
      if (io_rd && io_port == `IPW_PORT_DATA && cfg_mode_q) begin
        case (index_q)
          `IPW_IDX_DEVSEL:   io_rdata <= devsel_q;
          `IPW_IDX_ACTIVATE: io_rdata <= wd_sel ? {7'h00, active_q} : 8'h00;
          `IPW_IDX_UNIT:     io_rdata <= wd_sel ? unit_q : 8'h00;
          `IPW_IDX_COUNT:    io_rdata <= wd_sel ? count_q : 8'h00;
          `IPW_IDX_CTRL:     io_rdata <= wd_sel ?
            {mouse_en_q, kbd_en_q, 1'b0, timeout_q, 4'h0} : 8'h00;
          default:           io_rdata <= 8'h00;
        endcase
      end else if (io_rd) begin
        io_rdata <= 8'h00;
      end
    end
  end
endmodule // ipw_watchdog

// >>> tb/ipw_host.sv
// ipw_host.sv: host model issuing index and data port cycles.
// assumes the watchdog samples one-cycle strobes on clock.
`timescale 1ns/1ps
module ipw_host (
  input  wire       clock,
  output reg        io_wr,
  output reg        io_rd,
  output reg        io_port,
  output reg  [7:0] io_wdata,
  input  wire [7:0] io_rdata
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_port = 1'b0;
    io_wdata = 8'h00;
  end
  // released data goes inverted so nothing leans on a stale byte
  task wr(input p, input [7:0] d);
    begin
      @(posedge clock);
      io_wr <= 1'b1;
      io_port <= p;
      io_wdata <= d;
      @(posedge clock);
      io_wr <= 1'b0;
      io_wdata <= ~d;
    end
  endtask
  task rd(input p, output [7:0] d);
    begin
      @(posedge clock);
      io_rd <= 1'b1;
      io_port <= p;
      @(posedge clock);
      io_rd <= 1'b0;
      @(posedge clock);
      d = io_rdata;
    end
  endtask
endmodule // ipw_host

// >>> tb/ipw_properties.sv
// ipw_properties.sv: port-level checks for the watchdog.
// assumes one clock, synchronous reset; bound to ipw_watchdog.
`timescale 1ns/1ps
module ipw_props (
  input wire       clock,
  input wire       reset,
  input wire       io_wr,
  input wire       io_rd,
  input wire       io_port,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire       kbd_activity,
  input wire       mouse_activity,
  input wire       timeout_action_strap,
  input wire       irq11_n,
  input wire       sys_reset
);
  reg  [3:0] calm_q;
  reg        wr1_q;
  reg        wr2_q;
  // write history kept in flops; sampled-value calls stay inside properties
  always @(posedge clock) begin
    wr1_q <= io_wr;
    wr2_q <= wr1_q;
  end
  wire       calm = calm_q >= 4'h8;
  // activity restarts arrive late through the synchroniser
  always @(posedge clock)
    if (reset || kbd_activity || mouse_activity) calm_q <= 4'h0;
    else if (!calm) calm_q <= calm_q + 4'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire quiet = !io_wr && !wr1_q && !wr2_q && calm;
  property p_rst;
    disable iff (1'b0) reset |=> irq11_n && !sys_reset && io_rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_excl;
    !(!irq11_n && sys_reset);
  endproperty
  a_excl: assert property (p_excl) else $error("both timeout outputs active");
  property p_rdat;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdat: assert property (p_rdat) else $error("read data moved without read");
  property p_ihold;
    !irq11_n && quiet |=> !irq11_n;
  endproperty
  a_ihold: assert property (p_ihold) else $error("interrupt released early");
  property p_shold;
    sys_reset && quiet |=> sys_reset;
  endproperty
  a_shold: assert property (p_shold) else $error("system reset released early");
  property p_sstrap;
    $rose(sys_reset) |-> timeout_action_strap;
  endproperty
  a_sstrap: assert property (p_sstrap) else $error("reset against strap");
  property p_istrap;
    $fell(irq11_n) |-> !timeout_action_strap;
  endproperty
  a_istrap: assert property (p_istrap) else $error("interrupt against strap");
  property p_irel;
    $rose(irq11_n) |-> !calm || $past(io_wr) || $past(io_wr, 2) || $past(io_wr, 3);
  endproperty
  a_irel: assert property (p_irel) else $error("interrupt released without cause");
  c_irq: cover property ($fell(irq11_n));
  c_sys: cover property ($rose(sys_reset));
  c_rel: cover property ($rose(irq11_n));
endmodule // ipw_props
bind ipw_watchdog ipw_props i_props (.clock(clock), .reset(reset), .io_wr(io_wr),
  .io_rd(io_rd), .io_port(io_port), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
  .timeout_action_strap(timeout_action_strap), .irq11_n(irq11_n), .sys_reset(sys_reset));

// >>> tb/tb_top.sv
// tb_top.sv: self-checking bench for the watchdog.
// assumes ticks shortened to 10 cycles a second, 3 seconds a minute.
`timescale 1ns/1ps
module tb_top;
  reg        clock = 1'b0;
  reg        reset = 1'b1;
  reg        kbd = 1'b0;
  reg        mouse = 1'b0;
  reg        strap = 1'b0;
  wire       io_wr, io_rd, io_port, irq11_n, sys_reset;
  wire [7:0] io_wdata, io_rdata;
  integer    mismatches = 0;
  integer    n_compared = 0;
  reg  [7:0] v;
  always #5 clock = ~clock;
  ipw_host i_host (.clock(clock), .io_wr(io_wr), .io_rd(io_rd), .io_port(io_port),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  ipw_watchdog #(.CLK_HZ(10), .PER_MIN(3)) i_dut (.clock(clock), .reset(reset),
    .io_wr(io_wr), .io_rd(io_rd), .io_port(io_port), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .kbd_activity(kbd), .mouse_activity(mouse),
    .timeout_action_strap(strap), .irq11_n(irq11_n), .sys_reset(sys_reset));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("mismatches %0d, comparisons %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task cyc(input integer n); repeat (n) @(posedge clock); endtask
  // look just past the edge so registered outputs have settled
  task outs(input [1:0] e); begin #1; check({6'h00, sys_reset, irq11_n}, {6'h00, e}); end endtask
  task wreg(input [7:0] i, input [7:0] d); begin i_host.wr(0, i); i_host.wr(1, d); end endtask
  task rreg(input [7:0] i); begin i_host.wr(0, i); i_host.rd(1, v); end endtask
  task rst(input s); begin cyc(1); reset <= 1'b1; strap <= s; cyc(8); reset <= 1'b0; cyc(1); end endtask
  task pulse_kbd; begin kbd <= 1'b1; cyc(2); kbd <= 1'b0; cyc(8); end endtask
  task unlock;
    begin
      i_host.wr(0, 8'h87);
      i_host.wr(0, 8'h87);
      wreg(8'h07, 8'h08);
    end
  endtask
  task t_locked;
    begin
      rst(0);
      outs(2'b01);
      wreg(8'hf7, 8'h20);
      cyc(4);
      outs(2'b01);
      rreg(8'hf7);
      check(v, 8'h00);
      unlock;
      wreg(8'hf7, 8'h20);
      cyc(4);
      outs(2'b01);
    end
  endtask
  task t_count;
    begin
      wreg(8'h30, 8'h01);
      wreg(8'hf6, 8'h03);
      cyc(22);
      outs(2'b01);
      cyc(14);
      outs(2'b00);
      rreg(8'hf7);
      check(v & 8'h10, 8'h10);
      wreg(8'hf6, 8'h02);
      cyc(3);
      outs(2'b01);
      cyc(24);
      outs(2'b00);
    end
  endtask
  task t_activity;
    begin
      wreg(8'hf7, 8'h80);
      pulse_kbd;
      outs(2'b00);
      wreg(8'hf7, 8'h40);
      pulse_kbd;
      outs(2'b01);
      cyc(25);
      outs(2'b00);
      wreg(8'hf7, 8'hc0);
      mouse <= 1'b1;
      cyc(2);
      mouse <= 1'b0;
      cyc(8);
      outs(2'b01);
    end
  endtask
  task t_unit_force;
    begin
      wreg(8'hf5, 8'h08);
      wreg(8'hf6, 8'h01);
      cyc(22);
      outs(2'b01);
      cyc(14);
      outs(2'b00);
      wreg(8'hf6, 8'h00);
      cyc(3);
      outs(2'b01);
      wreg(8'hf7, 8'h20);
      cyc(3);
      outs(2'b00);
      rreg(8'hf7);
      check(v & 8'h30, 8'h10);
    end
  endtask
  task t_lock;
    begin
      wreg(8'h07, 8'h00);
      wreg(8'hf6, 8'h05);
      cyc(3);
      outs(2'b00);
      wreg(8'h07, 8'h08);
      i_host.wr(0, 8'haa);
      wreg(8'hf6, 8'h05);
      cyc(3);
      outs(2'b00);
    end
  endtask
  task t_strap;
    begin
      rst(1);
      unlock;
      wreg(8'h30, 8'h01);
      wreg(8'hf7, 8'h20);
      cyc(3);
      outs(2'b11);
    end
  endtask
  initial begin
    #20000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    t_locked;
    t_count;
    t_activity;
    t_unit_force;
    t_lock;
    t_strap;
    conclude;
  end
endmodule // tb_top
